// ==== hw/icc_cfg_ctrl.sv ====
// Overview of operation
// - I bit picks interrupt or extra output
// - Blink off: phase-0 level bit only
// - Blink on: level bit per active phase
// - Level 0 pulls pin low, 1 releases
// - Extra output shares blink and PWM behaviour
// - Extra output intensity from global nibble
// - G clear: per-port intensity, extra uses 0x0E
// - G set: all outputs use global nibble
// - D0 blink enable, D1 flip flag
// - D6 reads live blink pin level
// - D7 reads change flag; in interrupt mode pin low when set
// - Config register at 0x0F, bits D5-D0 writable
// - Phase is flip XOR blink pin when enabled
// - Reset gives interrupt mode, no blink, global
// - Flag follows input mismatch, resample clears
`default_nettype none
module icc_cfg_ctrl (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Register access from the serial engine
	input  wire icc_pkg::icc_req_t req,
	output logic [7:0]             rdata_ff,
	output logic                   rvalid_ff,
	// Status inputs
	input  wire logic              blink_pin,
	input  wire logic              data_changed,
	// Shared pin, open drain
	output logic                   irq_or_gpo_pin_o_ff,
	output logic                   irq_or_gpo_pin_oe_ff,
	// To PWM and port logic
	output logic                   blink_phase_ff,
	output logic                   global_int_ff,
	output logic [3:0]             extra_output_int_ff
);

	////////////////////////////////////////////////////////////////////////
	icc_pkg::icc_cfg_t cfg_ff;
	logic [3:0]        master_ff;
	logic              phase;
	logic              level;
	logic              pull_low;

	////////////////////////////////////////////////////////////////////////
	// One decode for every register access, so write and read agree
	function automatic logic reg_hit
	(
		input icc_pkg::icc_req_t r,
		input logic [7:0]        a,
		input logic              is_wr
	);
		if (is_wr)
			return r.wr && r.addr == a;
		return r.rd && r.addr == a;
	endfunction : reg_hit

	// Status bits are never stored, so no write can disturb them
	function automatic logic [7:0] cfg_image
	(
		input icc_pkg::icc_cfg_t c,
		input logic              irq_flag,
		input logic              blink_lvl
	);
		logic [7:0] img;
		img                        = {2'h0, c};
		img[icc_pkg::IRQ_FLAG_BIT] = irq_flag;
		img[icc_pkg::BLINK_IN_BIT] = blink_lvl;
		return img;
	endfunction : cfg_image

	// Level bit picked by the phase; the other one is ignored
	function automatic logic gpo_level
	(
		input icc_pkg::icc_cfg_t c,
		input logic              ph
	);
		return ph ? c.gpo_phase1_level : c.gpo_phase0_level;
	endfunction : gpo_level

	// Only D5-D0 store; D7/D6 writes dropped
	always_ff @(posedge clk)
	begin
		if (rst)
			cfg_ff <= icc_pkg::icc_cfg_t'(icc_pkg::CFG_RESET[5:0]);
		else if (reg_hit(req, icc_pkg::CFG_ADDR, 1'b1))
			cfg_ff <= icc_pkg::icc_cfg_t'(req.wdata[5:0] & icc_pkg::CFG_WR_MASK);
	end

	// Global nibble shadow, written at the master register address
	always_ff @(posedge clk)
	begin
		if (rst)
			master_ff <= icc_pkg::MASTER_RESET;
		else if (reg_hit(req, icc_pkg::MASTER_ADDR, 1'b1))
			master_ff <= req.wdata[3:0];
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		phase = cfg_ff.blink_en ? (cfg_ff.flip ^ blink_pin) : 1'b0;
		level = gpo_level(cfg_ff, phase);
		pull_low = cfg_ff.irq_en ? data_changed : ~level;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			irq_or_gpo_pin_o_ff  <= 1'b0;
			irq_or_gpo_pin_oe_ff <= 1'b0;
			blink_phase_ff       <= 1'b0;
			global_int_ff        <= 1'b1;
			extra_output_int_ff  <= icc_pkg::MASTER_RESET;
		end
		else
		begin
			irq_or_gpo_pin_o_ff  <= 1'b0;
			irq_or_gpo_pin_oe_ff <= pull_low;
			blink_phase_ff       <= phase;
			global_int_ff        <= cfg_ff.global_int;
			extra_output_int_ff  <= master_ff;
		end
	end

	// Read port: status bits always live
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			rvalid_ff <= reg_hit(req, icc_pkg::CFG_ADDR, 1'b0);
			rdata_ff  <= cfg_image(cfg_ff, data_changed, blink_pin);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus events and pin modes that the properties are built from
	sequence cfg_wr_s;
		req.wr && req.addr == icc_pkg::CFG_ADDR;
	endsequence

	sequence cfg_rd_s;
		req.rd && req.addr == icc_pkg::CFG_ADDR;
	endsequence

	sequence master_wr_s;
		req.wr && req.addr == icc_pkg::MASTER_ADDR;
	endsequence

	// Output mode, pointing at the phase-0 level bit
	sequence gpo_ph0_s;
		!cfg_ff.irq_en && !(cfg_ff.blink_en && (cfg_ff.flip ^ blink_pin));
	endsequence

	// Output mode, blinking, in phase 1
	sequence gpo_ph1_s;
		!cfg_ff.irq_en && cfg_ff.blink_en && (cfg_ff.flip ^ blink_pin);
	endsequence

	// Reset
	reset_cfg_a: assert property (@(posedge clk)
		$fell(rst) |-> !cfg_ff.blink_en && cfg_ff.irq_en && cfg_ff.global_int)
		else $error("config not at default after reset");
	reset_out_a: assert property (@(posedge clk)
		rst |=> !irq_or_gpo_pin_oe_ff && !irq_or_gpo_pin_o_ff && global_int_ff
		&& extra_output_int_ff == icc_pkg::MASTER_RESET && !rvalid_ff)
		else $error("outputs not at default after reset");

	// Shared pin
	irq_pin_a: assert property (@(posedge clk) disable iff (rst)
		cfg_ff.irq_en && data_changed |=> irq_or_gpo_pin_oe_ff)
		else $error("pin not low on interrupt");
	irq_release_a: assert property (@(posedge clk) disable iff (rst)
		cfg_ff.irq_en && !data_changed |=> !irq_or_gpo_pin_oe_ff)
		else $error("pin not released without interrupt");
	gpo_static_a: assert property (@(posedge clk) disable iff (rst)
		!cfg_ff.irq_en && !cfg_ff.blink_en
		|=> irq_or_gpo_pin_oe_ff == !$past(cfg_ff.gpo_phase0_level))
		else $error("static level wrong");
	gpo_blink_a: assert property (@(posedge clk) disable iff (rst)
		gpo_ph1_s |=> irq_or_gpo_pin_oe_ff == !$past(cfg_ff.gpo_phase1_level))
		else $error("phase 1 level wrong");
	gpo_phase0_a: assert property (@(posedge clk) disable iff (rst)
		gpo_ph0_s |=> irq_or_gpo_pin_oe_ff == !$past(cfg_ff.gpo_phase0_level))
		else $error("phase 0 level wrong");
	odrain_low_a: assert property (@(posedge clk) disable iff (rst)
		!irq_or_gpo_pin_o_ff)
		else $error("open-drain pin driven high");

	// Blink phase and intensity selects
	phase_xor_a: assert property (@(posedge clk) disable iff (rst)
		cfg_ff.blink_en |=> blink_phase_ff == $past(cfg_ff.flip ^ blink_pin))
		else $error("blink phase wrong");
	flip_ignored_a: assert property (@(posedge clk) disable iff (rst)
		!cfg_ff.blink_en |=> !blink_phase_ff)
		else $error("flip acted with blink off");
	master_path_a: assert property (@(posedge clk) disable iff (rst)
		master_wr_s ##1 1'b1 |=> extra_output_int_ff == $past(req.wdata[3:0], 2))
		else $error("extra output intensity wrong");
	global_sel_a: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> global_int_ff == $past(cfg_ff.global_int))
		else $error("global select wrong");

	// Register access
	status_rd_a: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> rdata_ff[7:6] == $past({data_changed, blink_pin}))
		else $error("status bits not live");
	write_cfg_a: assert property (@(posedge clk) disable iff (rst)
		cfg_wr_s |=> 6'(cfg_ff) == $past(req.wdata[5:0]))
		else $error("config write lost");
	cfg_hold_a: assert property (@(posedge clk) disable iff (rst)
		!(req.wr && req.addr == icc_pkg::CFG_ADDR) |=> $stable(cfg_ff))
		else $error("config changed without a write");
	rd_data_a: assert property (@(posedge clk) disable iff (rst)
		cfg_rd_s |=> rvalid_ff && rdata_ff[5:0] == $past(6'(cfg_ff)))
		else $error("config read back wrong");
	rd_quiet_a: assert property (@(posedge clk) disable iff (rst)
		!(req.rd && req.addr == icc_pkg::CFG_ADDR) |=> !rvalid_ff)
		else $error("read answered at wrong address");
endmodule : icc_cfg_ctrl
`default_nettype wire

// ==== hw/icc_pkg.sv ====
`default_nettype none
package icc_pkg;
	// Register map
	localparam logic [7:0] CFG_ADDR      = 8'h0f;
	localparam logic [7:0] MASTER_ADDR   = 8'h0e;
	localparam logic [7:0] CFG_RESET     = 8'h0c;
	localparam logic [3:0] MASTER_RESET  = 4'hf;
	localparam logic [5:0] CFG_WR_MASK   = 6'h3f;
	// Field positions within the configuration register
	localparam int BLINK_EN_BIT  = 0;
	localparam int FLIP_BIT      = 1;
	localparam int GLOBAL_BIT    = 2;
	localparam int IRQ_EN_BIT    = 3;
	localparam int PH0_LVL_BIT   = 4;
	localparam int PH1_LVL_BIT   = 5;
	localparam int BLINK_IN_BIT  = 6;
	localparam int IRQ_FLAG_BIT  = 7;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} icc_req_t;

	typedef struct packed {
		logic       gpo_phase1_level;
		logic       gpo_phase0_level;
		logic       irq_en;
		logic       global_int;
		logic       flip;
		logic       blink_en;
	} icc_cfg_t;
endpackage : icc_pkg
`default_nettype wire

// ==== test/icc_host.sv ====
`default_nettype none
module icc_host (
	// Clock and answer
	input  wire logic         clk,
	input  wire logic         rvalid,
	input  wire logic [7:0]   rdata,
	// Requests
	output var icc_pkg::icc_req_t req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial req = '0;
	// One-cycle strobe; the answer is waited on a few cycles only
	task automatic acc(input logic rd, input logic [7:0] a, d, output logic [7:0] q,
		output logic ok);
		int i;
		ok = !rd;
		q = 8'h00;
		@(posedge clk);
		#2 req = '{wr: !rd, rd: rd, addr: a, wdata: d};
		@(posedge clk);
		#2 req = '0;
		for (i = 0; i < 3 && !ok; i++)
		begin
			ok = rvalid;
			q = rdata;
			if (!ok) @(posedge clk) #2;
		end
	endtask : acc
endmodule : icc_host
`default_nettype wire

// ==== test/irq_gpo_pin_config_control_test.sv ====
`default_nettype none
module irq_gpo_pin_config_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, bp = 0, dc = 0, rv, o, oe, ph, gl, ok;
	logic [7:0] rd, q;
	logic [3:0] nib;
	icc_pkg::icc_req_t req;
	int n_mismatch = 0, compares = 0;
	// Config write, blink pin, change flag, pin pulled low, phase
	logic [11:0] rows [8] = '{12'hc86, 12'h088, 12'h202, 12'h104,
		12'h219, 12'h23a, 12'h133, 12'h168};
	always #25 clk = ~clk;
	icc_host host (.clk(clk), .rvalid(rv), .rdata(rd), .req(req));
	icc_cfg_ctrl uut (.clk(clk), .rst(rst), .req(req), .rdata_ff(rd), .rvalid_ff(rv),
		.blink_pin(bp), .data_changed(dc), .irq_or_gpo_pin_o_ff(o),
		.irq_or_gpo_pin_oe_ff(oe), .blink_phase_ff(ph), .global_int_ff(gl),
		.extra_output_int_ff(nib));
	task automatic chk(input logic [8:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	initial
	begin
		#100000 n_mismatch++;
		test_done;
	end
	initial
	begin
		repeat (4) @(posedge clk);
		#2 rst = 0;
		chk({o, oe, ph, gl, nib}, 8'h1f);
		host.acc(1, icc_pkg::CFG_ADDR, 8'h00, q, ok);
		chk({ok, q}, {1'b1, icc_pkg::CFG_RESET});
		foreach (rows[i])
		begin
			{bp, dc} = rows[i][3:2];
			host.acc(0, icc_pkg::CFG_ADDR, rows[i][11:4], q, ok);
			repeat (3) @(posedge clk);
			#2 chk({o, oe, ph}, {1'b0, rows[i][1:0]});
			chk(gl, rows[i][6]);
			host.acc(1, icc_pkg::CFG_ADDR, 8'h00, q, ok);
			chk({ok, q}, {1'b1, rows[i][2], rows[i][3], rows[i][9:4]});
		end
		host.acc(0, icc_pkg::MASTER_ADDR, 8'hf5, q, ok);
		host.acc(0, 8'h10, 8'hff, q, ok);
		repeat (2) @(posedge clk);
		#2 chk(nib, 4'h5);
		host.acc(1, icc_pkg::CFG_ADDR, 8'h00, q, ok);
		chk(q, 8'h56);
		host.acc(1, 8'h10, 8'h00, q, ok);
		chk(ok, 1'b0);
		// Reset in mid-run must drop the written state again
		@(posedge clk);
		#2 rst = 1;
		repeat (2) @(posedge clk);
		#2 rst = 0;
		chk({o, oe, ph, gl, nib}, 8'h1f);
		host.acc(1, icc_pkg::CFG_ADDR, 8'h00, q, ok);
		chk({ok, q}, {1'b1, 8'h4c});
		test_done;
	end
endmodule : irq_gpo_pin_config_control_test
`default_nettype wire
